/* hdl/fcs_sequencer.sv */
`timescale 1ns/1ps
`include "fcs_map.svh"
// Functional notes
// - excess-write flag set when page program ends with excessive write
// - program-error flag set on program error in page or lock program
// - erase-error flag set on erase error in block or erase-all
// - reset or controller-reset falling edge clears the three error flags
// - clear-status code clears status bits 5..3 in one cycle
// - ready flag 0 while engine runs, 1 at end; only four commands touch it
// - ready flag forced 1 on reset and controller-reset falling edge
// - ready-busy bit mirrors engine ready state
// - each block has a lock bit; 0 locked, 1 unlocked
// - lock bit cleared only by lock program, set only by erasing block
// - lock-disable 1 treats all blocks unlocked, stored bits kept
// - erase with lock-disable erases regardless and sets lock bits to 1
// - 16-bit accesses at even addresses; command upper byte ignored
// - read-array code gives array reads from next cycle until new command
// - after read-status code, a read returns the status register
// - auto program starts only after all 128 words received
// - reprogramming a programmed page raises no program error
// - erase code then confirm at block top address erases that block
// - erase-all code then confirm erases all unlocked blocks
// - lock code then confirm at block top clears that block lock bit
// - after read-lock code, read of block top gives lock bit on data bit 6
// - bad second-cycle code on two-cycle commands sets erase and program errors
// - read-array code in second cycle cancels command, back to array mode
// - controller-reset falling edge aborts engine, array mode, status 0x80
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int BLOCKS = 8,
  parameter int BLOCK_ADDR_BITS = 16,
  parameter int ADDR_BITS = 24,
  parameter int OP_CYCLES = `FCS_OP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cpu bus
  input wire fcs_bus_t bus,
  output logic [15:0] rdata,
  output logic arrayRead,
  // control register bits
  input wire logic lock_disable_bit,
  input wire logic controller_reset_bit,
  output logic ready_busy_bit,
  // program/erase engine
  output logic engineStart,
  output fcs_op_t engineOp,
  output logic [ADDR_BITS-1:0] engineAddr,
  output logic [BLOCKS-1:0] engineBlocks,
  output logic engineAbort,
  output logic pageWrite,
  output logic [6:0] pageIndex,
  output logic [15:0] pageData,
  input wire logic engineDone,
  input wire fcs_engine_result_t engineResult,
  // flash array read data
  input wire logic [15:0] arrayData
);
  localparam int BLK_IDX_BITS = $clog2(BLOCKS);
  localparam logic [BLOCK_ADDR_BITS-1:0] TOP_OFFSET = {{(BLOCK_ADDR_BITS-1){1'b1}}, 1'b0};

  fcs_state_t state;
  logic [7:0] flash_op_status;
  logic [BLOCKS-1:0] lockBit;
  logic ctrlResetPrev;
  logic ctrlReset;
  logic [6:0] wordCount;
  logic [31:0] opTimer;
  logic [7:0] cmd;
  logic [BLK_IDX_BITS-1:0] blkIdx;
  logic atBlockTop;
  logic blkLocked;
  logic [BLOCKS-1:0] effLocked;

  assign cmd = bus.wdata[7:0];
  assign blkIdx = bus.addr[BLOCK_ADDR_BITS +: BLK_IDX_BITS];
  assign atBlockTop = bus.addr[BLOCK_ADDR_BITS-1:0] == TOP_OFFSET;
  assign effLocked = lock_disable_bit ? '0 : ~lockBit;
  assign blkLocked = effLocked[blkIdx];
  assign ctrlReset = ctrlResetPrev && !controller_reset_bit;
  assign engineAbort = ctrlReset;
  assign ready_busy_bit = flash_op_status[`FCS_SR_READY];
  assign arrayRead = state == FCS_READ_ARRAY;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlResetPrev <= 1'b0;
    end else begin
      ctrlResetPrev <= controller_reset_bit;
    end
  end

  // command sequencing; host keeps quiet while busy, so writes then are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FCS_READ_ARRAY;
      wordCount <= 7'h00;
      engineStart <= 1'b0;
      engineOp <= FCS_OP_PROG;
      engineAddr <= '0;
      engineBlocks <= '0;
      pageWrite <= 1'b0;
      pageIndex <= 7'h00;
      pageData <= 16'h0000;
      opTimer <= 32'h0;
    end else begin
      engineStart <= 1'b0;
      pageWrite <= 1'b0;
      if (ctrlReset) begin
        state <= FCS_READ_ARRAY;
        opTimer <= 32'h0;
      end else if (state == FCS_BUSY) begin
        if (opTimer != 32'h0) begin
          opTimer <= opTimer - 32'h1;
        end
        if (engineDone) begin
          state <= FCS_READ_STATUS;
        end
      end else if (bus.wr) begin
        unique case (state)
          FCS_PAGE_LOAD: begin
            pageWrite <= 1'b1;
            pageIndex <= bus.addr[7:1];
            pageData <= bus.wdata;
            engineAddr <= bus.addr;
            wordCount <= wordCount + 7'h01;
            if (wordCount == 7'(`FCS_PAGE_WORDS - 1)) begin
              engineOp <= FCS_OP_PROG;
              engineBlocks <= '0;
              engineBlocks[blkIdx] <= ~blkLocked;
              engineStart <= 1'b1;
              opTimer <= 32'(OP_CYCLES);
              state <= FCS_BUSY;
            end
          end
          FCS_WAIT_ERASE, FCS_WAIT_ERASE_ALL, FCS_WAIT_LOCK: begin
            if (cmd == `FCS_CMD_CONFIRM && (state == FCS_WAIT_ERASE_ALL || atBlockTop)) begin
              engineAddr <= bus.addr;
              engineStart <= 1'b1;
              opTimer <= 32'(OP_CYCLES);
              state <= FCS_BUSY;
              engineBlocks <= '0;
              if (state == FCS_WAIT_ERASE_ALL) begin
                engineOp <= FCS_OP_ERASE_ALL;
                engineBlocks <= ~effLocked;
              end else if (state == FCS_WAIT_ERASE) begin
                engineOp <= FCS_OP_ERASE;
                engineBlocks[blkIdx] <= ~blkLocked;
              end else begin
                engineOp <= FCS_OP_LOCK;
                engineBlocks[blkIdx] <= 1'b1;
              end
            end else if (cmd == `FCS_CMD_READ_ARRAY) begin
              state <= FCS_READ_ARRAY;
            end else begin
              state <= FCS_READ_STATUS;
            end
          end
          default: begin
            wordCount <= 7'h00;
            unique case (cmd)
              `FCS_CMD_READ_ARRAY: state <= FCS_READ_ARRAY;
              `FCS_CMD_READ_STATUS: state <= FCS_READ_STATUS;
              `FCS_CMD_READ_LOCK: state <= FCS_READ_LOCK;
              `FCS_CMD_PAGE_PROGRAM: state <= FCS_PAGE_LOAD;
              `FCS_CMD_BLOCK_ERASE: state <= FCS_WAIT_ERASE;
              `FCS_CMD_ERASE_ALL: state <= FCS_WAIT_ERASE_ALL;
              `FCS_CMD_LOCK_PROGRAM: state <= FCS_WAIT_LOCK;
              default: state <= state;
            endcase
          end
        endcase
      end
    end
  end

  // status register; hardware error set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_op_status <= `FCS_SR_RESET;
    end else if (ctrlReset) begin
      flash_op_status <= `FCS_SR_RESET;
    end else begin
      if (state != FCS_BUSY && bus.wr && state != FCS_PAGE_LOAD && cmd == `FCS_CMD_CLEAR_STATUS &&
          state != FCS_WAIT_ERASE && state != FCS_WAIT_ERASE_ALL && state != FCS_WAIT_LOCK) begin
        flash_op_status[5:3] <= 3'h0;
      end
      if (engineStart) begin
        flash_op_status[`FCS_SR_READY] <= 1'b0;
      end
      if (state == FCS_BUSY && engineDone) begin
        flash_op_status[`FCS_SR_READY] <= 1'b1;
        // overwrite of programmed data is not an error; engine reports none
        if (engineOp == FCS_OP_PROG && engineResult.excessWrite) begin
          flash_op_status[`FCS_SR_EXCESS] <= 1'b1;
        end
        if ((engineOp == FCS_OP_PROG || engineOp == FCS_OP_LOCK) && engineResult.programError) begin
          flash_op_status[`FCS_SR_PROGERR] <= 1'b1;
        end
        if ((engineOp == FCS_OP_ERASE || engineOp == FCS_OP_ERASE_ALL) && engineResult.eraseError) begin
          flash_op_status[`FCS_SR_ERASEERR] <= 1'b1;
        end
      end
      if (bus.wr && (state == FCS_WAIT_ERASE || state == FCS_WAIT_ERASE_ALL || state == FCS_WAIT_LOCK) &&
          cmd != `FCS_CMD_CONFIRM && cmd != `FCS_CMD_READ_ARRAY) begin
        flash_op_status[`FCS_SR_PROGERR] <= 1'b1;
        flash_op_status[`FCS_SR_ERASEERR] <= 1'b1;
      end
    end
  end

  // error flags follow the engine report only in the cycle that ends the operation
  excess_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp == FCS_OP_PROG && engineResult.excessWrite)
    |=> flash_op_status[`FCS_SR_EXCESS]) else $error("excess flag not set");
  prog_err_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp inside {FCS_OP_PROG, FCS_OP_LOCK} &&
     engineResult.programError) |=> flash_op_status[`FCS_SR_PROGERR]) else $error("program flag not set");
  erase_err_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp inside {FCS_OP_ERASE, FCS_OP_ERASE_ALL} &&
     engineResult.eraseError) |=> flash_op_status[`FCS_SR_ERASEERR]) else $error("erase flag not set");
  err_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlReset |=> flash_op_status[5:3] == 3'h0) else $error("error flags not cleared");
  ready_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlReset |=> ready_busy_bit) else $error("ready not forced high");
  ready_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone) |=> flash_op_status[`FCS_SR_READY]) else $error("ready not set");
  ready_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && !engineDone && !ctrlReset) |=> !flash_op_status[`FCS_SR_READY])
    else $error("ready high while busy");
  seq_err_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE_ALL && cmd != `FCS_CMD_CONFIRM && cmd != `FCS_CMD_READ_ARRAY)
    |=> flash_op_status[5:4] == 2'b11) else $error("sequence error missing");

  // lock bits; flip-flops stand in for the nonvolatile cells, erased state is 1
  generate
    for (genvar b = 0; b < BLOCKS; b++) begin : g_lock
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lockBit[b] <= 1'b1;
        end else if (state == FCS_BUSY && engineDone && !ctrlReset && engineBlocks[b]) begin
          if (engineOp == FCS_OP_LOCK && !engineResult.programError) begin
            lockBit[b] <= 1'b0;
          end else if ((engineOp == FCS_OP_ERASE || engineOp == FCS_OP_ERASE_ALL) &&
                       !engineResult.eraseError) begin
            lockBit[b] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // lock bits move only in the cycle that ends an engine operation
  lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state != FCS_BUSY || !engineDone) |=> $stable(lockBit)) else $error("lock bits moved");
  lock_prog_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp == FCS_OP_LOCK && !engineResult.programError)
    |=> (lockBit & engineBlocks) == '0) else $error("lock bit not cleared");
  blk_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp == FCS_OP_ERASE && !engineResult.eraseError)
    |=> (lockBit & engineBlocks) == engineBlocks) else $error("block erase left locked");
  locked_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE_ALL && cmd == `FCS_CMD_CONFIRM && !lock_disable_bit)
    |=> (engineBlocks & ~lockBit) == '0) else $error("locked block selected");
  disable_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE && cmd == `FCS_CMD_CONFIRM && atBlockTop && lock_disable_bit)
    |=> engineBlocks != '0) else $error("override ignored");

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      unique case (state)
        FCS_READ_STATUS, FCS_BUSY: rdata <= {8'h00, flash_op_status};
        FCS_READ_LOCK: rdata <= 16'(lockBit[blkIdx]) << `FCS_LOCK_DATA_BIT;
        default: rdata <= arrayData;
      endcase
    end
  end

  sr_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlReset |=> flash_op_status == `FCS_SR_RESET) else $error("status not reset");
  ready_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (engineStart && !ctrlReset) |=> !flash_op_status[`FCS_SR_READY]) else $error("ready not low while busy");
  ready_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    ready_busy_bit == flash_op_status[7]) else $error("ready-busy mismatch");
  seq_error_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_LOCK && cmd != 8'hD0 && cmd != 8'hFF)
    |=> flash_op_status[5:4] == 2'b11) else $error("sequence error missing");
  cancel_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE && cmd == 8'hFF) |=> arrayRead)
    else $error("cancel not to array");
  erase_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FCS_BUSY && engineDone && !ctrlReset && engineOp == FCS_OP_ERASE_ALL && !engineResult.eraseError)
    |=> (lockBit & engineBlocks) == engineBlocks) else $error("erase left locked");
  lock_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lock_disable_bit) |=> $stable(lockBit)) else $error("lock bits altered");
  clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && state == FCS_READ_ARRAY && cmd == 8'h50 && !ctrlReset) |=> flash_op_status[5:3] == 3'h0)
    else $error("clear status failed");

  // command decode and start conditions
  page_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_PAGE_LOAD && wordCount != 7'h7F) |=> !engineStart && state == FCS_PAGE_LOAD)
    else $error("early page start");
  erase_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE && cmd == `FCS_CMD_CONFIRM && atBlockTop)
    |=> engineStart && engineOp == FCS_OP_ERASE) else $error("block erase not started");
  erase_all_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_ERASE_ALL && cmd == `FCS_CMD_CONFIRM)
    |=> engineStart && engineOp == FCS_OP_ERASE_ALL) else $error("erase all not started");
  lock_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_LOCK && cmd == `FCS_CMD_CONFIRM && atBlockTop)
    |=> engineStart && engineOp == FCS_OP_LOCK) else $error("lock program not started");
  cancel_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state == FCS_WAIT_LOCK && cmd == `FCS_CMD_READ_ARRAY) |=> arrayRead)
    else $error("lock cancel not to array");
  array_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !ctrlReset && state != FCS_BUSY && state != FCS_PAGE_LOAD && cmd == `FCS_CMD_READ_ARRAY)
    |=> arrayRead) else $error("read array not entered");
  abort_array_a: assert property (@(posedge clk) disable iff (!rst_n)
    ctrlReset |=> arrayRead) else $error("abort not to array");

  // read data paths
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && state == FCS_READ_STATUS) |=> rdata == {8'h00, $past(flash_op_status)})
    else $error("status read wrong");
  lock_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && state == FCS_READ_LOCK) |=> (rdata & 16'hFFBF) == 16'h0000)
    else $error("lock read has stray bits");
  // timer is only a watch on engine latency, it never gates anything
  op_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
    opTimer <= 32'(OP_CYCLES)) else $error("timer out of range");
endmodule

/* include/fcs_map.svh */
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
`define FCS_CMD_READ_ARRAY 8'hFF
`define FCS_CMD_READ_STATUS 8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PAGE_PROGRAM 8'h41
`define FCS_CMD_BLOCK_ERASE 8'h20
`define FCS_CMD_ERASE_ALL 8'hA7
`define FCS_CMD_LOCK_PROGRAM 8'h77
`define FCS_CMD_READ_LOCK 8'h71
`define FCS_CMD_CONFIRM 8'hD0
`define FCS_SR_EXCESS 3
`define FCS_SR_PROGERR 4
`define FCS_SR_ERASEERR 5
`define FCS_SR_READY 7
`define FCS_SR_RESET 8'h80
`define FCS_LOCK_DATA_BIT 6
`define FCS_PAGE_WORDS 128
`define FCS_OP_TIME_NS 2000
`define FCS_CLK_NS 10
`define FCS_OP_CYCLES ((`FCS_OP_TIME_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`endif

/* include/fcs_pkg.sv */
package fcs_pkg;
  typedef enum {
    FCS_READ_ARRAY,
    FCS_READ_STATUS,
    FCS_READ_LOCK,
    FCS_PAGE_LOAD,
    FCS_WAIT_ERASE,
    FCS_WAIT_ERASE_ALL,
    FCS_WAIT_LOCK,
    FCS_BUSY
  } fcs_state_t;
  typedef enum {FCS_OP_PROG, FCS_OP_ERASE, FCS_OP_ERASE_ALL, FCS_OP_LOCK} fcs_op_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fcs_bus_t;
  typedef struct packed {
    logic excessWrite;
    logic programError;
    logic eraseError;
  } fcs_engine_result_t;
endpackage

/* verification/fcs_engine_model.sv */
`timescale 1ns/1ps
module fcs_engine_model
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // engine side of the sequencer
  input wire logic engineStart,
  input wire logic engineAbort,
  input wire logic [9:0] delay,
  input wire fcs_engine_result_t failSet,
  output logic engineDone,
  output fcs_engine_result_t engineResult
);
  logic [9:0] count;
  logic busy;
  // result is only valid with done; garbage otherwise so stale use shows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= '0;
      engineDone <= 1'b0;
      engineResult <= '0;
    end else begin
      engineDone <= 1'b0;
      engineResult <= ~failSet;
      if (engineAbort) begin
        busy <= 1'b0;
      end else if (engineStart) begin
        busy <= 1'b1;
        count <= delay;
      end else if (busy && count == 10'h000) begin
        busy <= 1'b0;
        engineDone <= 1'b1;
        engineResult <= failSet;
      end else if (busy) begin
        count <= count - 10'h001;
      end
    end
  end
endmodule

/* verification/fcs_sequencer_tb_top.sv */
`timescale 1ns/1ps
module fcs_sequencer_tb_top
  import fcs_pkg::*;
;
  logic clk = 0;
  logic rst_n = 0;
  fcs_bus_t bus = '0;
  logic [15:0] rdata, pageData, d;
  logic [15:0] arrayData = 16'h5A3C;
  logic lockDisable = 0;
  logic ctrlReset = 0;
  logic arrayRead, readyBusy, engineStart, engineAbort, engineDone, pageWrite;
  fcs_op_t engineOp;
  logic [23:0] engineAddr;
  logic [7:0] engineBlocks;
  logic [6:0] pageIndex;
  logic [9:0] delay = 10'h014;
  fcs_engine_result_t failSet = '0;
  fcs_engine_result_t engineResult;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  fcs_sequencer u_fcs_sequencer (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .arrayRead(arrayRead),
    .lock_disable_bit(lockDisable), .controller_reset_bit(ctrlReset), .ready_busy_bit(readyBusy),
    .engineStart(engineStart), .engineOp(engineOp), .engineAddr(engineAddr), .engineBlocks(engineBlocks),
    .engineAbort(engineAbort), .pageWrite(pageWrite), .pageIndex(pageIndex), .pageData(pageData),
    .engineDone(engineDone), .engineResult(engineResult), .arrayData(arrayData));
  fcs_engine_model u_fcs_engine_model (.clk(clk), .rst_n(rst_n), .engineStart(engineStart),
    .engineAbort(engineAbort), .delay(delay), .failSet(failSet), .engineDone(engineDone),
    .engineResult(engineResult));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  function automatic logic [23:0] top(input int b);
    return (24'(b) << 16) | 24'h00FFFE;
  endfunction
  task automatic status(input logic [15:0] exp);
    wr(24'h000000, 16'hC370);
    rd(24'h000000);
    chk(d, exp);
  endtask
  task automatic wait_ready;
    int i;
    i = 0;
    while (readyBusy !== 1'b1 && i < 1000) begin
      @(posedge clk);
      i++;
    end
    #1 chk({15'h0000, readyBusy}, 16'h0001);
  endtask
  // two-cycle command, returns once engineStart has had its edge
  task automatic op2(input logic [15:0] cmd, input logic [23:0] a);
    wr(24'h000000, cmd);
    wr(a, 16'h00D0);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic lockbit(input int b, input logic exp);
    wr(24'h000000, 16'h0071);
    rd(top(b));
    chk({15'h0000, d[6]}, {15'h0000, exp});
  endtask
  task automatic t_erase;
    failSet = '{excessWrite: 1'b0, programError: 1'b0, eraseError: 1'b1};
    op2(16'h0020, top(1));
    chk({15'h0000, readyBusy}, 16'h0000);
    chk({8'h00, engineBlocks}, 16'h0002);
    wait_ready();
    status(16'h00A0);
    wr(24'h000000, 16'h0050);
    status(16'h0080);
  endtask
  task automatic t_seq;
    wr(24'h000000, 16'h0020);
    wr(top(0), 16'h0012);
    status(16'h00B0);
    wr(24'h000000, 16'h0050);
    wr(24'h000000, 16'h00A7);
    wr(24'h000000, 16'h00FF);
    rd(24'h000100);
    chk(d, arrayData);
    chk({15'h0000, arrayRead}, 16'h0001);
    arrayData <= 16'hC3A5;
    rd(24'h000102);
    chk(d, 16'hC3A5);
  endtask
  task automatic t_lock;
    failSet = '0;
    op2(16'h0077, top(2));
    wait_ready();
    lockbit(2, 1'b0);
    op2(16'h0020, top(2));
    chk({8'h00, engineBlocks}, 16'h0000);
    wait_ready();
    op2(16'h00A7, 24'h000000);
    chk({8'h00, engineBlocks}, 16'h00FB);
    wait_ready();
    lockbit(2, 1'b0);
    lockDisable <= 1'b1;
    op2(16'h0020, top(2));
    chk({8'h00, engineBlocks}, 16'h0004);
    wait_ready();
    lockDisable <= 1'b0;
    lockbit(2, 1'b1);
    wr(24'h000000, 16'h0050);
  endtask
  task automatic t_page;
    failSet = '{excessWrite: 1'b1, programError: 1'b0, eraseError: 1'b0};
    wr(24'h000000, 16'h0041);
    for (int i = 0; i < 127; i++) begin
      wr(24'h010000 | 24'(i * 2), 16'(i));
    end
    @(posedge clk);
    #1 chk({15'h0000, readyBusy}, 16'h0001);
    wr(24'h0100FE, 16'h007F);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, readyBusy}, 16'h0000);
    chk({9'h000, pageIndex}, 16'h007F);
    chk(pageData, 16'h007F);
    chk(engineAddr[15:0], 16'h00FE);
    chk(16'(engineOp), 16'(FCS_OP_PROG));
    chk({8'h00, engineBlocks}, 16'h0002);
    wait_ready();
    status(16'h0088);
    failSet = '{excessWrite: 1'b0, programError: 1'b1, eraseError: 1'b0};
    op2(16'h0077, top(4));
    wait_ready();
    status(16'h0098);
  endtask
  task automatic t_abort;
    failSet = '{excessWrite: 1'b0, programError: 1'b0, eraseError: 1'b1};
    op2(16'h0020, top(5));
    @(posedge clk);
    ctrlReset <= 1'b1;
    @(posedge clk);
    ctrlReset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, readyBusy}, 16'h0001);
    chk({15'h0000, arrayRead}, 16'h0001);
    status(16'h0080);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    status(16'h0080);
    t_erase();
    t_seq();
    t_lock();
    t_page();
    t_abort();
    finish_test();
  end
endmodule
